// ==== rtl/tsc_slave_cmd.sv ====
// command and status logic of a two-wire bus slave, reached over ahb-lite
// assumes a bit engine (address match, shift register, start/stop detector)
// beside it that reports bus events as one-cycle pulses on hclk
`timescale 1ns/100ps
`include "tsc_map.svh"

module tsc_slave_cmd #(
	parameter int ADDR_W = 12
) (
	input  wire logic             hclk,
	input  wire logic             hresetn,
	input  wire logic             hsel,
	input  wire logic [ADDR_W-1:0] haddr,
	input  wire logic [1:0]       htrans,
	input  wire logic             hwrite,
	input  wire logic [2:0]       hsize,
	input  wire logic [31:0]      hwdata,
	input  wire logic             hready,
	output logic      [31:0]      hrdata,
	output logic                  hreadyout,
	output logic                  hresp,
	input  wire logic             addr_match,
	input  wire logic             addr_rw,
	input  wire logic             stop_seen,
	input  wire logic             start_seen,
	input  wire logic             byte_done,
	input  wire logic             ack_seen_valid,
	input  wire logic             ack_seen_value,
	input  wire logic             clash_seen,
	input  wire logic             violation_seen,
	input  wire logic             host_enable,
	input  wire logic             rx_valid,
	input  wire logic [7:0]       rx_byte,
	output logic                  act_strobe,
	output logic                  act_do_ack,
	output logic                  act_ack_value,
	output tsc_pkg::tsc_act_t     act_kind,
	output logic      [7:0]       tx_byte,
	output logic                  scl_hold,
	output logic                  sda_quiet,
	output logic                  event_line
);

	// index decode needs bits up to the data register word
	if (ADDR_W < 8) begin : g_chk
		$error("tsc_slave_cmd: ADDR_W must be at least 8");
	end

	// true when a word address hits the given register index
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [5:0] idx);
		hit = (a[ADDR_W-1:2] == (ADDR_W-2)'(idx)) && (a[1:0] == 2'h0);
	endfunction

	// follow-up operation chosen by code, direction and last event
	function automatic tsc_pkg::tsc_act_t pick(input logic [1:0] code, input logic rd,
			input tsc_pkg::tsc_ev_t ev);
		// finishing ignores the last event: it only waits for a start
		if (code == `TSC_CMD_FINISH)
			pick = tsc_pkg::TSC_ACT_WAIT_START;
		else if (!rd)
			pick = tsc_pkg::TSC_ACT_RECV;
		else if (ev == tsc_pkg::TSC_EV_DATA)
			pick = tsc_pkg::TSC_ACT_BYTE_THEN_ACK;
		else
			pick = tsc_pkg::TSC_ACT_DATA_EVENT;
	endfunction

	// one bit placed at its field position, so positions stay in the map header
	function automatic logic [7:0] put(input logic v, input int pos);
		put = `TSC_RST_BYTE;
		put[pos] = v;
	endfunction

	// a byte register widened to the bus word; upper bits read zero
	function automatic logic [31:0] widen(input logic [7:0] b);
		widen = {24'h00_0000, b};
	endfunction

	// state held by this block
	logic                auto_continue_enable;
	logic                ack_response_select;
	logic                data_event_flag;
	logic                addr_stop_event_flag;
	logic                scl_stretch_active;
	logic                master_ack_seen;
	logic                drive_clash_flag;
	logic                bus_violation_flag;
	logic                dir_read;
	logic                event_cause;
	logic [7:0]          slave_shift_data;
	tsc_pkg::tsc_ev_t    last_ev;

	// pending data phase of a write
	logic                wr_pend;
	logic [ADDR_W-1:0]   wr_addr;

	// address phase decode; narrower transfers are dropped, each register is a whole word
	wire                 word_size;
	wire                 addr_ph;
	wire                 rd_take;
	wire                 wr_take;
	assign word_size = hsize == `TSC_HSIZE_WORD;
	assign addr_ph = hsel & hready & htrans[`TSC_HTRANS_ACT_B] & word_size;
	assign rd_take = addr_ph & ~hwrite;
	assign wr_take = addr_ph & hwrite;

	// register hits for reads (address phase) and writes (data phase)
	wire                 rd_ctrl;
	wire                 rd_cmd;
	wire                 rd_state;
	wire                 rd_data;
	assign rd_ctrl  = rd_take & hit(haddr, `TSC_IDX_CTRL);
	assign rd_cmd   = rd_take & hit(haddr, `TSC_IDX_CMD);
	assign rd_state = rd_take & hit(haddr, `TSC_IDX_STATE);
	assign rd_data  = rd_take & hit(haddr, `TSC_IDX_DATA);

	// write hits use the address kept from the address phase
	wire                 wr_ctrl;
	wire                 wr_cmd;
	wire                 wr_state;
	wire                 wr_data;
	assign wr_ctrl  = wr_pend & hit(wr_addr, `TSC_IDX_CTRL);
	assign wr_cmd   = wr_pend & hit(wr_addr, `TSC_IDX_CMD);
	assign wr_state = wr_pend & hit(wr_addr, `TSC_IDX_STATE);
	assign wr_data  = wr_pend & hit(wr_addr, `TSC_IDX_DATA);

	// low byte of the write data; every register is one byte wide
	wire [7:0]           wr_byte;
	assign wr_byte = hwdata[`TSC_BYTE_HI:`TSC_BYTE_LO];

	// command field of the write; strobes never stored
	wire [1:0]           cmd_code;
	wire                 cmd_valid;
	wire                 cmd_new_ack;
	assign cmd_code    = hwdata[`TSC_CMD_HI:`TSC_CMD_LO];
	// codes 0 and 1 are not executing codes, so no strobe is sent and no flag clears
	assign cmd_valid   = wr_cmd & cmd_code[1];
	// a command uses the ack value written in the same word
	assign cmd_new_ack = hwdata[`TSC_BIT_ACKSEL];

	// data register access; it only drives the bus in auto-continue
	wire                 data_acc;
	wire                 data_go;
	assign data_acc = rd_data | wr_data;
	// only a held bus is resumed; an access in mid-byte must not restart the engine
	assign data_go  = data_acc & auto_continue_enable & scl_stretch_active;

	// anything that resumes the engine; command always wins the cycle
	wire                 go;
	wire [1:0]           go_code;
	wire                 go_ack;
	assign go      = cmd_valid | data_go;
	assign go_code = cmd_valid ? cmd_code : `TSC_CMD_RESPOND;
	assign go_ack  = wr_cmd ? cmd_new_ack : ack_response_select;

	// clear terms: implicit on access/command (clash on start, violation never), explicit on write one
	wire                 clr_auto;
	wire                 clr_data_ev;
	wire                 clr_addr_ev;
	wire                 clr_clash;
	wire                 clr_viol;
	assign clr_auto    = data_acc | cmd_valid;
	assign clr_data_ev = clr_auto | (wr_state & hwdata[`TSC_BIT_DATA_EV]);
	assign clr_addr_ev = clr_auto | (wr_state & hwdata[`TSC_BIT_ADDR_EV]);
	assign clr_clash   = start_seen | (wr_state & hwdata[`TSC_BIT_CLASH]);
	assign clr_viol    = wr_state & hwdata[`TSC_BIT_VIOL];

	// set terms; a set in the same cycle as a clear wins
	wire                 set_data_ev;
	wire                 set_addr_ev;
	wire                 set_viol;
	// byte_done also fires at the end of a clashed byte
	assign set_data_ev = byte_done;
	assign set_addr_ev = addr_match | stop_seen;
	// the detector lives in the master logic, so it must be on
	assign set_viol    = violation_seen & host_enable;

	// next flag values: set term first, so a same-cycle clear loses
	wire                 next_data_ev;
	wire                 next_addr_ev;
	wire                 next_clash;
	wire                 next_viol;
	assign next_data_ev = set_data_ev | (data_event_flag & ~clr_data_ev);
	assign next_addr_ev = set_addr_ev | (addr_stop_event_flag & ~clr_addr_ev);
	assign next_clash   = clash_seen | (drive_clash_flag & ~clr_clash);
	assign next_viol    = set_viol | (bus_violation_flag & ~clr_viol);

	// control word; only the auto-continue bit has storage behind it
	wire [7:0]           ctrl_word;
	assign ctrl_word = put(auto_continue_enable, `TSC_BIT_AUTO);

	// command word; the strobe field is never stored, so it reads zero
	wire [7:0]           cmd_word;
	assign cmd_word = put(ack_response_select, `TSC_BIT_ACKSEL);

	// status word as software sees it
	wire [7:0]           state_word;
	assign state_word = put(data_event_flag, `TSC_BIT_DATA_EV)
		| put(addr_stop_event_flag, `TSC_BIT_ADDR_EV)
		| put(scl_stretch_active, `TSC_BIT_STRETCH)
		| put(master_ack_seen, `TSC_BIT_ACKSEEN)
		| put(drive_clash_flag, `TSC_BIT_CLASH)
		| put(bus_violation_flag, `TSC_BIT_VIOL)
		| put(dir_read, `TSC_BIT_DIR)
		| put(event_cause, `TSC_BIT_CAUSE);

	// read mux; unmapped words read zero
	wire [31:0]          next_rdata;
	assign next_rdata =
		rd_ctrl  ? widen(ctrl_word) :
		rd_cmd   ? widen(cmd_word) :
		rd_state ? widen(state_word) :
		rd_data  ? widen(slave_shift_data) :
		`TSC_RST_WORD;

	// bus side: zero wait state, always okay
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata    <= `TSC_RST_WORD;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			wr_pend   <= 1'b0;
			wr_addr   <= '0;
		end else begin
			hrdata    <= next_rdata;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			// the address is kept for the data phase, when hwdata arrives
			wr_pend   <= wr_take;
			wr_addr   <= haddr;
		end
	end

	// software control bits
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			auto_continue_enable <= 1'b0;
			ack_response_select  <= 1'b0;
		end else begin
			if (wr_ctrl)
				auto_continue_enable <= hwdata[`TSC_BIT_AUTO];
			// ack select is stored on every command write, executing or not
			if (wr_cmd)
				ack_response_select <= hwdata[`TSC_BIT_ACKSEL];
		end
	end

	// event flags and stretch; the request line follows the address/stop event only
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			data_event_flag      <= 1'b0;
			addr_stop_event_flag <= 1'b0;
			scl_stretch_active   <= 1'b0;
			drive_clash_flag     <= 1'b0;
			bus_violation_flag   <= 1'b0;
			event_line           <= 1'b0;
		end else begin
			data_event_flag      <= next_data_ev;
			addr_stop_event_flag <= next_addr_ev;
			// stretch drops on the same edge as the last pending flag
			scl_stretch_active   <= next_data_ev | next_addr_ev;
			drive_clash_flag     <= next_clash;
			bus_violation_flag   <= next_viol;
			event_line           <= next_addr_ev;
		end
	end

	// captured bus facts: direction, cause, master acknowledge
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dir_read        <= 1'b0;
			event_cause     <= 1'b0;
			master_ack_seen <= 1'b0;
		end else begin
			if (addr_match)
				dir_read <= addr_rw;
			if (addr_match)
				event_cause <= 1'b1;
			else if (stop_seen)
				event_cause <= 1'b0;
			if (ack_seen_valid)
				master_ack_seen <= ack_seen_value;
		end
	end

	// last raised event decides what code 3 means
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			last_ev <= tsc_pkg::TSC_EV_NONE;
		end else begin
			case (1'b1)
				addr_match: last_ev <= tsc_pkg::TSC_EV_ADDR;
				byte_done:  last_ev <= tsc_pkg::TSC_EV_DATA;
				// a stop forgets it, so the next address decides code 3
				stop_seen:  last_ev <= tsc_pkg::TSC_EV_NONE;
				default:    last_ev <= last_ev;
			endcase
		end
	end

	// shift data: software write wins, the engine can't shift while held
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			slave_shift_data <= `TSC_RST_BYTE;
		end else if (wr_data) begin
			slave_shift_data <= wr_byte;
		end else if (rx_valid) begin
			slave_shift_data <= rx_byte;
		end
	end

	// finishing a master read skips the ack action
	wire                 next_do_ack;
	assign next_do_ack = ~((go_code == `TSC_CMD_FINISH) & dir_read);

	// one-cycle request to the bit engine
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			act_strobe    <= 1'b0;
			act_do_ack    <= 1'b0;
			act_ack_value <= 1'b0;
			act_kind      <= tsc_pkg::TSC_ACT_WAIT_START;
		end else begin
			act_strobe <= go;
			if (go) begin
				act_do_ack    <= next_do_ack;
				act_ack_value <= go_ack;
				act_kind      <= pick(go_code, dir_read, last_ev);
			end
		end
	end

	// pin-facing levels; clash silences every low bit for the operation
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_byte   <= `TSC_RST_BYTE;
			scl_hold  <= 1'b0;
			sda_quiet <= 1'b0;
		end else begin
			// a fresh write shows at once, so the engine never sends a stale byte
			tx_byte   <= wr_data ? wr_byte : slave_shift_data;
			scl_hold  <= next_data_ev | next_addr_ev;
			sda_quiet <= next_clash;
		end
	end

endmodule

// ==== rtl/tsc_map.svh ====
// register map, field positions and reset values of the slave command/status block
// assumes a 32-bit ahb-lite slave, one aligned word per register index
`ifndef TSC_MAP_SVH
`define TSC_MAP_SVH
// register indices; byte address is four times the index
`define TSC_IDX_CTRL      6'h09
`define TSC_IDX_CMD       6'h0a
`define TSC_IDX_STATE     6'h0b
`define TSC_IDX_DATA      6'h0d
// control register field
`define TSC_BIT_AUTO      1
// command register fields
`define TSC_BIT_ACKSEL    2
`define TSC_CMD_HI        1
`define TSC_CMD_LO        0
// data register byte within the bus word
`define TSC_BYTE_HI       7
`define TSC_BYTE_LO       0
// command codes
`define TSC_CMD_NONE      2'h0
`define TSC_CMD_RSVD      2'h1
`define TSC_CMD_FINISH    2'h2
`define TSC_CMD_RESPOND   2'h3
// status register fields
`define TSC_BIT_DATA_EV   7
`define TSC_BIT_ADDR_EV   6
`define TSC_BIT_STRETCH   5
`define TSC_BIT_ACKSEEN   4
`define TSC_BIT_CLASH     3
`define TSC_BIT_VIOL      2
`define TSC_BIT_DIR       1
`define TSC_BIT_CAUSE     0
// reset values
`define TSC_RST_BYTE      8'h00
`define TSC_RST_WORD      32'h0000_0000
// ahb-lite encodings
`define TSC_HTRANS_BUSY_B 0
`define TSC_HTRANS_ACT_B  1
`define TSC_HSIZE_WORD    3'h2
`endif

// ==== rtl/tsc_pkg.sv ====
// types shared by the slave command/status block
// assumes the map header supplies every number
package tsc_pkg;
	// follow-up operation handed to the bit engine
	typedef enum logic [1:0] {
		TSC_ACT_RECV,
		TSC_ACT_DATA_EVENT,
		TSC_ACT_BYTE_THEN_ACK,
		TSC_ACT_WAIT_START
	} tsc_act_t;
	// which event the slave last raised
	typedef enum logic [1:0] {
		TSC_EV_NONE,
		TSC_EV_ADDR,
		TSC_EV_DATA
	} tsc_ev_t;
endpackage

// ==== verif/tsc_slave_cmd_checker.sv ====
// assertions on the outputs of the slave command/status block
// assumes a bind into tsc_slave_cmd, one clock domain
`timescale 1ns/100ps
module tsc_slave_cmd_checker (
	input wire logic              hclk,
	input wire logic              hresetn,
	input wire logic              addr_match,
	input wire logic              stop_seen,
	input wire logic              start_seen,
	input wire logic              clash_seen,
	input wire logic              byte_done,
	input wire logic              act_strobe,
	input wire logic              act_do_ack,
	input wire logic              act_ack_value,
	input wire tsc_pkg::tsc_act_t act_kind,
	input wire logic              scl_hold,
	input wire logic              sda_quiet,
	input wire logic              event_line
);
	default clocking @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// event inputs must land in the flags one edge later
	AST_ADDR_STOP: assert property (addr_match || stop_seen |=> event_line && scl_hold)
		else $error("address or stop event not raised");
	AST_BYTE_DONE: assert property (byte_done |=> scl_hold)
		else $error("byte end did not stretch");
	AST_CLASH: assert property (clash_seen |=> sda_quiet)
		else $error("clash did not silence sda");
	AST_START_CLR: assert property (start_seen && !clash_seen |=> !sda_quiet)
		else $error("start left clash flag set");
	// a strobe clears the pending address/stop event unless a new one arrived
	AST_CMD_CLR: assert property (act_strobe && !$past(addr_match) && !$past(stop_seen) |-> !event_line)
		else $error("strobe left event pending");
	AST_ACK_DO: assert property (act_strobe && act_kind != tsc_pkg::TSC_ACT_WAIT_START |-> act_do_ack)
		else $error("ack action skipped");
	AST_EVENT_LINE: assert property (event_line |-> scl_hold)
		else $error("event without stretch");
	AST_ACK_HOLD: assert property (!act_strobe |-> $stable(act_ack_value) && $stable(act_kind))
		else $error("action changed without strobe");
endmodule

// ==== verif/tsc_engine_model.sv ====
// far-side bit engine: answers each strobe except a wait-for-start with one byte end
// assumes one-cycle pulses on hclk, reset shared with the slave
`timescale 1ns/100ps
module tsc_engine_model (
	input  wire logic              hclk,
	input  wire logic              hresetn,
	input  wire logic              act_strobe,
	input  wire tsc_pkg::tsc_act_t act_kind,
	input  wire logic              slow,
	input  wire logic              master_nack,
	output logic                   byte_done,
	output logic                   ack_seen_valid,
	output logic                   ack_seen_value,
	output logic                   rx_valid,
	output logic      [7:0]        rx_byte
);
	logic [2:0] wait_cnt;
	logic       recv_q;
	wire        go   = act_strobe && act_kind != tsc_pkg::TSC_ACT_WAIT_START;
	wire        fire = wait_cnt == 3'h1;
	// even the fast answer lands after the bench's status read that follows a command
	// slow mode delays the byte end, and so the next stretch, by three cycles
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wait_cnt <= 3'h0;
			recv_q   <= 1'b0;
		end else if (go) begin
			wait_cnt <= slow ? 3'h7 : 3'h4;
			recv_q   <= act_kind == tsc_pkg::TSC_ACT_RECV;
		end else if (wait_cnt != 3'h0) begin
			wait_cnt <= wait_cnt - 3'h1;
		end
	end
	// data byte changes every cycle so a stale capture shows up
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) rx_byte <= 8'h00;
		else rx_byte <= {rx_byte[6:0], ~rx_byte[7]};
	end
	assign byte_done      = fire;
	assign rx_valid       = fire && recv_q;
	assign ack_seen_valid = fire && !recv_q;
	assign ack_seen_value = master_nack;
endmodule

// ==== verif/i2c_slave_command_status_bench.sv ====
// self-checking bench of the slave command/status block over ahb-lite
// assumes the engine model answers strobes; bus events are pulsed here
`timescale 1ns/100ps
`include "tsc_map.svh"
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
	$display("unexpected %s exp %h got %h", n, e, g); end end
module i2c_slave_command_status_bench;
	localparam logic [11:0] A_CTRL = {4'h0, `TSC_IDX_CTRL, 2'h0};
	localparam logic [11:0] A_CMD  = {4'h0, `TSC_IDX_CMD, 2'h0};
	localparam logic [11:0] A_STAT = {4'h0, `TSC_IDX_STATE, 2'h0};
	localparam logic [11:0] A_DATA = {4'h0, `TSC_IDX_DATA, 2'h0};
	logic              hclk, hresetn, hsel, hwrite, hready, hresp, host_enable, slow, master_nack;
	logic              byte_done, ack_seen_valid, ack_seen_value, rx_valid, act_strobe, act_do_ack;
	logic              act_ack_value, scl_hold, sda_quiet, event_line, dir, ack, ack_rx, cl, vi, cause;
	logic [1:0]        htrans;
	logic [2:0]        hsize;
	logic [4:0]        ev;
	logic [11:0]       haddr;
	logic [31:0]       hwdata, hrdata, rd;
	logic [7:0]        rx_byte, tx_byte, last_rx;
	tsc_pkg::tsc_act_t act_kind;
	int                n_errors, n_checks, cyc, n_strobe, s;
	tsc_slave_cmd dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hrdata, .hreadyout(hready), .hresp, .addr_match(ev[0]), .addr_rw(dir),
		.stop_seen(ev[1]), .start_seen(ev[2]), .byte_done, .ack_seen_valid, .ack_seen_value,
		.clash_seen(ev[3]), .violation_seen(ev[4]), .host_enable, .rx_valid, .rx_byte, .act_strobe,
		.act_do_ack, .act_ack_value, .act_kind, .tx_byte, .scl_hold, .sda_quiet, .event_line);
	tsc_engine_model eng_u (.hclk, .hresetn, .act_strobe, .act_kind, .slow, .master_nack, .byte_done,
		.ack_seen_valid, .ack_seen_value, .rx_valid, .rx_byte);
	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end
	// strobe count, last byte handed over, and the hang limit
	always @(posedge hclk) begin
		cyc++;
		if (act_strobe === 1'b1) n_strobe++;
		if (rx_valid === 1'b1) last_rx = rx_byte;
		if (cyc == 20000) begin
			n_errors++;
			summarize();
		end
	end
	task automatic summarize();
		if (n_errors == 0 && n_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// one single transfer; the wait ends only on hready
	task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		hsize <= 3'h2;
		do @(posedge hclk); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge hclk); while (hready !== 1'b1);
		rd = hrdata;
		`CHK("response", 1'b0, hresp)
	endtask
	task automatic pulse(input logic [4:0] m);
		ev <= m;
		@(posedge hclk);
		ev <= 5'h00;
	endtask
	function automatic logic [31:0] exp_st(input logic d, input logic a);
		exp_st = {24'h0, d, a, d | a, ack_rx, cl, vi, dir, cause};
	endfunction
	task automatic chk_st(input logic d, input logic a);
		bus(1'b0, A_STAT, 32'h0000_0000);
		`CHK("status", exp_st(d, a), rd)
		`CHK("event line", a, event_line)
		`CHK("sda quiet", cl, sda_quiet)
	endtask
	task automatic cmd(input logic k_ack, input logic [1:0] code, input logic go, input tsc_pkg::tsc_act_t k);
		bus(1'b1, A_CMD, {29'h0, k_ack, code});
		#1;
		`CHK("strobe", go, act_strobe)
		if (go) begin
			`CHK("kind", k, act_kind)
			`CHK("ack value", k_ack, act_ack_value)
			`CHK("do ack", k != tsc_pkg::TSC_ACT_WAIT_START || !dir, act_do_ack)
		end
		@(posedge hclk);
	endtask
	task automatic wait_hold();
		for (int t = 0; t < 40 && scl_hold !== 1'b1; t++) @(posedge hclk);
		`CHK("stretch", 1'b1, scl_hold)
	endtask
	initial begin
		{hsel, hwrite, htrans, hsize, haddr, hwdata, ev, dir, host_enable, slow, master_nack} <= '0;
		hresetn <= 1'b0;
		{ack_rx, cl, vi, cause} = 4'h0;
		void'($urandom(27));
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		// control, command, status, an unmapped word and data all read zero
		for (int i = 0; i < 5; i++) begin
			bus(1'b0, {4'h0, `TSC_IDX_CTRL + 6'(i), 2'h0}, 32'h0000_0000);
			`CHK("reset read", 32'h0000_0000, rd)
		end
		for (int i = 0; i < 8; i++) begin
			dir <= 1'($urandom);
			ack = 1'($urandom);
			slow <= 1'($urandom);
			master_nack <= 1'($urandom);
			pulse(5'h01);
			cause = 1'b1;
			chk_st(0, 1);
			cmd(ack, 2'(i % 2), 0, act_kind);
			chk_st(0, 1);
			cmd(ack, 2'h3, 1, dir ? tsc_pkg::TSC_ACT_DATA_EVENT : tsc_pkg::TSC_ACT_RECV);
			bus(1'b0, A_CMD, 32'h0000_0000);
			`CHK("command", {29'h0, ack, 2'h0}, rd)
			chk_st(0, 0);
			wait_hold();
			if (dir) ack_rx = master_nack;
			chk_st(1, 0);
			if (!dir) begin
				s = n_strobe;
				bus(1'b0, A_DATA, 32'h0000_0000);
				@(posedge hclk);
				`CHK("data", {24'h0, last_rx}, rd)
				`CHK("strobes", s, n_strobe)
				chk_st(0, 0);
			end
			cmd(~ack, 2'h3, 1, dir ? tsc_pkg::TSC_ACT_BYTE_THEN_ACK : tsc_pkg::TSC_ACT_RECV);
			wait_hold();
			if (dir) ack_rx = master_nack;
			chk_st(1, 0);
			cmd(ack, 2'h2, 1, tsc_pkg::TSC_ACT_WAIT_START);
			chk_st(0, 0);
		end
		// stop, write-one-to-clear, collision and bus violation
		pulse(5'h02);
		cause = 1'b0;
		chk_st(0, 1);
		bus(1'b1, A_STAT, 32'h0000_00bf);
		chk_st(0, 1);
		bus(1'b1, A_STAT, 32'h0000_0040);
		chk_st(0, 0);
		pulse(5'h08);
		cl = 1'b1;
		chk_st(0, 0);
		pulse(5'h04);
		cl = 1'b0;
		chk_st(0, 0);
		pulse(5'h10);
		chk_st(0, 0);
		host_enable <= 1'b1;
		pulse(5'h18);
		{cl, vi} = 2'h3;
		chk_st(0, 0);
		bus(1'b1, A_STAT, 32'h0000_000c);
		{cl, vi} = 2'h0;
		chk_st(0, 0);
		// with auto-continue a data read strobes and a write loads the byte
		bus(1'b1, A_CTRL, 32'h0000_0002);
		pulse(5'h01);
		s = n_strobe;
		bus(1'b0, A_DATA, 32'h0000_0000);
		@(posedge hclk);
		`CHK("strobes", s + 1, n_strobe)
		wait_hold();
		hwdata <= 32'($urandom);
		@(posedge hclk);
		bus(1'b1, A_DATA, hwdata);
		@(posedge hclk);
		`CHK("tx byte", hwdata[7:0], tx_byte)
		summarize();
	end
endmodule
bind tsc_slave_cmd tsc_slave_cmd_checker chk_u (.hclk, .hresetn, .addr_match, .stop_seen, .start_seen,
	.clash_seen, .byte_done, .act_strobe, .act_do_ack, .act_ack_value, .act_kind, .scl_hold, .sda_quiet,
	.event_line);
